/* File: verilog/tpo_pkg.sv */
package tpo_pkg;
  // timing: one millisecond tick from the core clock
  localparam int CLK_MHZ  = 125;
  localparam int TICK_US  = 1000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int MS_PER_S = 1000;
  localparam int MS_PER_S_PCT = 10;  // ms per second per percent
  // apb byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CYC0 = 8'h04;  // +4 per channel
  localparam logic [7:0] A_MIN0 = 8'h0c;
  localparam logic [7:0] A_MV0  = 8'h14;
  localparam logic [7:0] A_OPTY = 8'h1c;
  localparam logic [7:0] A_ASG0 = 8'h20;  // +4 per output
  localparam logic [7:0] A_POL  = 8'h34;
  localparam logic [7:0] A_STAT = 8'h38;
  // cycle length limits, seconds
  localparam logic [6:0] CYC_MIN       = 7'h01;
  localparam logic [6:0] CYC_MAX       = 7'h78;
  localparam logic [6:0] CYC_RELAY_MIN = 7'h05;
  localparam logic [6:0] CYC_RST_PULSE = 7'h02;
  localparam logic [6:0] CYC_RST_OTHER = 7'h0a;
  localparam logic [6:0] CYC_LONG      = 7'h0a;
  // minimum on/off time, milliseconds; duty limit, percent
  localparam logic [7:0] MIN_MAX   = 8'hfa;
  localparam logic [7:0] MIN_FLOOR = 8'h32;
  localparam logic [7:0] MIN_LONG  = 8'hfa;
  localparam logic [7:0] MIN_SHORT = 8'h01;
  localparam logic [6:0] MV_MAX    = 7'h64;
  // cycle mode codes
  localparam logic MODE_CTRL = 1'b0;
  localparam logic MODE_LIFE = 1'b1;
  // output operation types
  typedef enum logic [2:0] {
    OP_DEFAULT = 3'h0, OP_HEAT = 3'h1, OP_COOL = 3'h2, OP_ANDOR = 3'h3,
    OP_ORAND = 3'h4, OP_ANY = 3'h5, OP_ALL = 3'h6
  } tpo_op_t;
  // source codes for inputs a..d
  localparam logic [5:0] SRC_ON   = 6'h01;
  localparam logic [5:0] SRC_EVT  = 6'h02;
  localparam logic [5:0] SRC_HEAT = 6'h0e;
  localparam logic [5:0] SRC_COOL = 6'h0f;
  localparam logic [5:0] SRC_DI   = 6'h12;
  // field layout
  localparam int OP_W  = 3;
  localparam int SRC_W = 6;
  localparam int POL_W = 4;
  // input a reset per output, output 0 in the low field
  localparam logic [29:0] ASG_A_RST = {6'h04, 6'h03, 6'h02, 6'h0f, 6'h0e};
  // status fields
  localparam int ST_DRV  = 0;
  localparam int ST_OUT  = 2;
  localparam int ST_INIT = 7;
  localparam int ST_RLY  = 8;
  localparam logic [1:0] STARTUP_WAIT = 2'h3;
endpackage

/* File: verilog/tpo_channel.sv */
`timescale 1ns/1ps
`default_nettype none
// one time-proportional channel: cycle counter, duty compare, hold timer
module tpo_channel
  import tpo_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       tick,     // 1 ms strobe
  input  wire logic       mode,     // shared cycle mode
  input  wire logic [6:0] cycle_s,  // effective cycle, s
  input  wire logic [6:0] mv_pct,   // duty, percent
  input  wire logic [7:0] min_ms,   // effective hold, ms
  output logic            drive
);
  logic [16:0] pos;      // ms into the cycle
  logic [16:0] cyc_ms;   // cycle in ms
  logic [16:0] on_ms;    // on share in ms
  logic [7:0]  hold;     // ms since last switch, saturating
  logic        on_used;  // turn-on spent this cycle
  logic        off_used; // turn-off spent this cycle
  logic        wrap;
  logic        want;
  logic        sw;

  assign cyc_ms = 17'(cycle_s) * 17'(MS_PER_S);
  assign on_ms  = 17'(cycle_s) * 17'(mv_pct) * 17'(MS_PER_S_PCT); // see R16
  // >= so a shortened cycle ends at once instead of running to overflow
  assign wrap   = pos >= cyc_ms - 17'h00001;
  assign want   = pos < on_ms; // see R16
  // switch only after the hold time; life mode allows one of each per cycle
  assign sw = tick && (want != drive) && (hold >= min_ms) // see R8
              && (mode == MODE_CTRL || (want ? !on_used : !off_used)); // see R3

  // cycle position
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pos <= '0; // see R17
    end else if (tick) begin
      pos <= wrap ? '0 : pos + 17'h00001;
    end
  end

  // hold timer restarts on each switch
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold <= '0;
    end else if (sw) begin
      hold <= '0; // see R8
    end else if (tick && hold != 8'hff) begin
      hold <= hold + 8'h01;
    end
  end

  // per-cycle transition budget; a switch beats the cycle clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      on_used  <= 1'b0;
      off_used <= 1'b0;
    end else begin
      if (tick && wrap) begin
        on_used  <= 1'b0;
        off_used <= 1'b0;
      end
      if (sw && want) on_used <= 1'b1; // see R3
      if (sw && !want) off_used <= 1'b1;
    end
  end

  // drive state
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      drive <= 1'b0; // see R17
    end else if (sw) begin
      drive <= want;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/tpo_top.sv */
// Function
// R1: relay path accepts cycle 5 to 120 s
// R2: non-relay path accepts cycle 1 to 120 s
// R3: mode 0 controllability, 1 one switch each
// R4: one cycle mode serves both channels
// R5: cycle resets 2 s pulse, else 10 s
// R6: mode resets 0 if output 1 pulse
// R7: relay or event path raises cycle to 5 s
// R8: hold state for minimum time after switching
// R9: zero minimum gives 250 ms or 1 ms
// R10: relay minimum 1-49 gives 50 ms
// R11: operation type 0 default, 1 heat, 2 cool
// R12: types 3 to 6 combine inputs a-d
// R13: default type follows drive or internal event
// R14: inputs a-d chosen by source code
// R15: per-input polarity inverts, resets direct
// R16: on share of cycle equals percentage
// R17: 1 ms tick, reset clears to off
`timescale 1ns/1ps
`default_nettype none
module tpo_top
  import tpo_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC // core clocks per ms
)(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [1:0]  ctl_is_pulse, // strap: control output is pulse type
  input  wire logic [1:0]  di_pin,       // digital input pins
  input  wire logic [4:0]  int_event,    // internal event results, same clock
  output logic             heat_drive,
  output logic             cool_drive,
  output logic [1:0]       ctl_out,
  output logic [2:0]       evt_out
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  // refuse a tick period the counter cannot make
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  // configuration
  logic [6:0]  cyc [2];     // cycle setting, s
  logic [7:0]  minset [2];  // minimum time setting, ms
  logic [6:0]  mv [2];      // duty, percent
  logic        mode;        // shared cycle mode
  logic [14:0] optype;      // 3 bits per output
  logic [23:0] asg [5];     // sources a..d per output
  logic [19:0] pol;         // 4 bits per output
  // startup
  logic [1:0]  init_cnt;
  logic        init_done;
  // pin synchronisers
  logic [1:0]  st_s1, st_s2, st_s3;
  logic [1:0]  di_s1, di_s2, di_s3;
  logic [1:0]  di_f;        // filtered digital inputs
  // timing
  logic [TW-1:0] tick_cnt;
  logic          tick;
  // derived per channel
  logic [1:0]  relay;       // channel reaches a relay or event output
  logic [6:0]  eff_cyc [2];
  logic [7:0]  eff_min [2];
  logic [1:0]  drv;
  // bus
  logic        wr;
  logic        mapped;
  logic [31:0] rd_val;

  // 1 ms tick
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + TW'(1);
    end
  end
  assign tick = tick_cnt == TW'(TICK_CYCLES - 1); // see R17

  // straps and pins pass three flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_s1 <= '0;
      st_s2 <= '0;
      st_s3 <= '0;
      di_s1 <= '0;
      di_s2 <= '0;
      di_s3 <= '0;
    end else begin
      st_s1 <= ctl_is_pulse;
      st_s2 <= st_s1;
      st_s3 <= st_s2;
      di_s1 <= di_pin;
      di_s2 <= di_s1;
      di_s3 <= di_s2;
    end
  end

  // a pin change counts once stages two and three agree
  for (genvar i = 0; i < 2; i++) begin : g_di
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        di_f[i] <= 1'b0;
      end else if (di_s2[i] == di_s3[i]) begin
        di_f[i] <= di_s3[i];
      end
    end
  end

  // startup wait; strap-dependent defaults load once the straps settle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      init_cnt  <= '0;
      init_done <= 1'b0;
    end else if (!init_done) begin
      init_cnt  <= init_cnt + 2'h1;
      init_done <= init_cnt == STARTUP_WAIT;
    end
  end

  function automatic logic [6:0] clamp_cyc(input logic [31:0] v);
    if (v < 32'(CYC_MIN)) return CYC_MIN; // see R2
    if (v > 32'(CYC_MAX)) return CYC_MAX; // see R1
    return v[6:0];
  endfunction

  function automatic logic [7:0] clamp_min(input logic [31:0] v);
    return (v > 32'(MIN_MAX)) ? MIN_MAX : v[7:0]; // see R8
  endfunction

  function automatic logic [6:0] clamp_mv(input logic [31:0] v);
    return (v > 32'(MV_MAX)) ? MV_MAX : v[6:0];
  endfunction

  assign wr = psel && penable && pwrite;

  // register writes; the defaults load beats a write in the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc[0]    <= CYC_RST_OTHER;
      cyc[1]    <= CYC_RST_OTHER;
      minset[0] <= '0;
      minset[1] <= '0;
      mv[0]     <= '0;
      mv[1]     <= '0;
      mode      <= MODE_LIFE;
      optype    <= '0; // see R11
      pol       <= '0; // see R15
      for (int k = 0; k < 5; k++) begin
        asg[k] <= {18'h00000, ASG_A_RST[k*SRC_W +: SRC_W]};
      end
    end else if (!init_done && init_cnt == STARTUP_WAIT) begin
      for (int c = 0; c < 2; c++) begin
        cyc[c] <= st_s3[c] ? CYC_RST_PULSE : CYC_RST_OTHER; // see R5
      end
      mode <= st_s3[0] ? MODE_CTRL : MODE_LIFE; // see R6
    end else if (wr) begin
      for (int c = 0; c < 2; c++) begin
        if (paddr == A_CYC0 + 8'(4 * c)) cyc[c] <= clamp_cyc(pwdata);
        if (paddr == A_MIN0 + 8'(4 * c)) minset[c] <= clamp_min(pwdata);
        if (paddr == A_MV0 + 8'(4 * c)) mv[c] <= clamp_mv(pwdata);
      end
      for (int k = 0; k < 5; k++) begin
        if (paddr == A_ASG0 + 8'(4 * k)) asg[k] <= pwdata[23:0]; // see R14
      end
      if (paddr == A_CTRL) mode <= pwdata[0]; // see R4
      if (paddr == A_OPTY) optype <= pwdata[14:0];
      if (paddr == A_POL) pol <= pwdata[19:0];
    end
  end

  // which channel reaches a relay or event output, by routing
  always_comb begin
    logic [2:0] op;
    logic       use_c;
    relay = '0;
    op    = '0;
    use_c = 1'b0;
    for (int k = 0; k < 5; k++) begin
      op = optype[k*OP_W +: OP_W];
      for (int c = 0; c < 2; c++) begin
        use_c = (op == 3'(c + 1)) || (op == OP_DEFAULT && k == c);
        for (int j = 0; j < 4; j++) begin
          if (op >= OP_ANDOR && op <= OP_ALL && asg[k][j*SRC_W +: SRC_W] == SRC_HEAT + 6'(c)) use_c = 1'b1;
        end
        // event outputs are relays; control outputs unless strapped pulse
        if (use_c && (k >= 2 || !st_s3[k[0]])) relay[c] = 1'b1;
      end
    end
  end

  // effective cycle, minimum time and the channel itself
  for (genvar c = 0; c < 2; c++) begin : g_ch
    always_comb begin
      if (relay[c] && cyc[c] < CYC_RELAY_MIN) begin
        eff_cyc[c] = CYC_RELAY_MIN; // see R7
      end else begin
        eff_cyc[c] = cyc[c];
      end
    end

    always_comb begin
      if (minset[c] == 8'h00) begin
        // zero setting: long hold for relays or long cycles
        eff_min[c] = (relay[c] || eff_cyc[c] >= CYC_LONG) ? MIN_LONG : MIN_SHORT; // see R9
      end else if (relay[c] && minset[c] < MIN_FLOOR) begin
        eff_min[c] = MIN_FLOOR; // see R10
      end else begin
        eff_min[c] = minset[c];
      end
    end

    tpo_channel u_ch (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .tick     (tick),
      .mode     (mode),
      .cycle_s  (eff_cyc[c]),
      .mv_pct   (mv[c]),
      .min_ms   (eff_min[c]),
      .drive    (drv[c])
    );
  end

  assign heat_drive = drv[0];
  assign cool_drive = drv[1];

  // source code to bit; undefined codes read as off
  function automatic logic src_bit(input logic [5:0] code, input logic [1:0] d,
                                   input logic [4:0] ev, input logic [1:0] di);
    if (code == SRC_ON) return 1'b1;
    if (code >= SRC_EVT && code < SRC_EVT + 6'h05) return ev[3'(code - SRC_EVT)];
    if (code == SRC_HEAT) return d[0]; // see R14
    if (code == SRC_COOL) return d[1];
    if (code == SRC_DI || code == SRC_DI + 6'h01) return di[1'(code - SRC_DI)];
    return 1'b0;
  endfunction

  // output selection and combination, registered
  for (genvar k = 0; k < 5; k++) begin : g_out
    logic [3:0] in;   // a..d after polarity
    logic       dflt; // default source
    logic       nxt;
    logic       q;

    always_comb begin
      for (int j = 0; j < 4; j++) begin
        in[j] = src_bit(asg[k][j*SRC_W +: SRC_W], drv, int_event, di_f)
                ^ pol[k*POL_W + j]; // see R15
      end
    end

    // split per output kind so no out-of-range index is ever elaborated
    if (k < 2) begin : g_dflt_ctl
      assign dflt = drv[k]; // see R13
    end else begin : g_dflt_evt
      assign dflt = int_event[k - 2]; // see R13
    end

    always_comb begin
      unique case (optype[k*OP_W +: OP_W])
        OP_DEFAULT: nxt = dflt; // see R11
        OP_HEAT:    nxt = drv[0];
        OP_COOL:    nxt = drv[1];
        OP_ANDOR:   nxt = (in[0] & in[1]) | (in[2] & in[3]); // see R12
        OP_ORAND:   nxt = (in[0] | in[1]) & (in[2] | in[3]);
        OP_ANY:     nxt = |in;
        OP_ALL:     nxt = &in;
        default:    nxt = 1'b0; // code 7 is not a type
      endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        q <= 1'b0; // see R17
      end else begin
        q <= nxt;
      end
    end

    if (k < 2) begin : g_ctl
      assign ctl_out[k] = q;
    end else begin : g_evt
      assign evt_out[k - 2] = q;
    end
  end

  // read mux
  always_comb begin
    rd_val = '0;
    mapped = 1'b1;
    if (paddr == A_CTRL) begin
      rd_val[0] = mode;
    end else if (paddr == A_OPTY) begin
      rd_val[14:0] = optype;
    end else if (paddr == A_POL) begin
      rd_val[19:0] = pol;
    end else if (paddr == A_STAT) begin
      rd_val[ST_DRV +: 2] = drv;
      rd_val[ST_OUT +: 5] = {evt_out, ctl_out};
      rd_val[ST_INIT]     = init_done;
      rd_val[ST_RLY +: 2] = relay;
    end else begin
      mapped = 1'b0;
      for (int c = 0; c < 2; c++) begin
        if (paddr == A_CYC0 + 8'(4 * c)) begin
          rd_val[6:0] = cyc[c];
          mapped = 1'b1;
        end
        if (paddr == A_MIN0 + 8'(4 * c)) begin
          rd_val[7:0] = minset[c];
          mapped = 1'b1;
        end
        if (paddr == A_MV0 + 8'(4 * c)) begin
          rd_val[6:0] = mv[c];
          mapped = 1'b1;
        end
      end
      for (int k = 0; k < 5; k++) begin
        if (paddr == A_ASG0 + 8'(4 * k)) begin
          rd_val[23:0] = asg[k];
          mapped = 1'b1;
        end
      end
    end
  end

  // data and error captured in the setup cycle, so the access ends at once
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? 32'h00000000 : rd_val;
      pslverr <= !mapped;
    end
  end

  assign pready = 1'b1;
endmodule
`default_nettype wire

/* File: verification/tpo_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module tpo_top_assertions
  import tpo_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC // clocks per ms
)(
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [1:0]  ctl_is_pulse,
  input wire logic [1:0]  di_pin,
  input wire logic [4:0]  int_event,
  input wire logic        heat_drive,
  input wire logic        cool_drive,
  input wire logic [1:0]  ctl_out,
  input wire logic [2:0]  evt_out
);
  logic [14:0] op;    // snooped op types
  logic [14:0] op_d;  // one cycle older
  logic [1:0]  prv;   // last drive states
  int          age_h; // clocks since heat switch
  int          age_c; // clocks since cool switch
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // op snoop, so mux checks know the selection
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      op   <= '0;
      op_d <= '0;
    end else begin
      if (psel && penable && pwrite && paddr == A_OPTY) begin
        op <= pwdata[14:0];
      end
      op_d <= op;
    end
  end
  // switch age, saturates so it cannot wrap
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prv   <= 2'h0;
      age_h <= 0;
      age_c <= 0;
    end else begin
      prv   <= {cool_drive, heat_drive};
      age_h <= (heat_drive != prv[0]) ? 1 : ((age_h > TICK_CYCLES) ? age_h : age_h + 1);
      age_c <= (cool_drive != prv[1]) ? 1 : ((age_c > TICK_CYCLES) ? age_c : age_c + 1);
    end
  end
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > A_STAT))
    else $error("pslverr wrong for address");
  a_err_data: assert property (psel && penable && pslverr |-> prdata == 32'h0)
    else $error("read data not zero on error");
  a_reset_off: assert property ($rose(arst_n) |-> !heat_drive && !cool_drive && ctl_out == 2'h0)
    else $error("output on after reset");
  a_heat_hold: assert property (heat_drive != prv[0] |-> age_h >= TICK_CYCLES)
    else $error("heat drive switched too soon");
  a_cool_hold: assert property (cool_drive != prv[1] |-> age_c >= TICK_CYCLES)
    else $error("cool drive switched too soon");
  a_ctl1_follow: assert property (op[2:0] == 3'h0 && op_d[2:0] == 3'h0 |-> ctl_out[0] == $past(heat_drive))
    else $error("control output 1 not following heat drive");
  a_evt1_follow: assert property (op[8:6] == 3'h0 && op_d[8:6] == 3'h0 |-> evt_out[0] == $past(int_event[0]))
    else $error("event output 1 not following event");
  a_evt1_heat: assert property (op[8:6] == 3'h1 && op_d[8:6] == 3'h1 |-> evt_out[0] == $past(heat_drive))
    else $error("event output 1 not following heat drive");
endmodule
bind tpo_top tpo_top_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);
`default_nettype wire

/* File: verification/tpo_out_drv.sv */
`timescale 1ns/1ps
`default_nettype none
// far side: fitted drivers, strap pins and field contacts
module tpo_out_drv #(
  parameter logic [1:0] PULSE = 2'h1 // control output 1 is pulse type
)(
  input  wire logic       core_clk,
  input  wire logic [1:0] ctl_out,
  input  wire logic [2:0] evt_out,
  output logic      [1:0] ctl_is_pulse,
  output logic      [1:0] di_pin
);
  logic [4:0] last; // previous output levels
  int         wear; // closures on all five outputs, pulse type included, for life estimates
  assign ctl_is_pulse = PULSE;
  initial di_pin = 2'h0;
  initial wear = 0;
  // count every closing contact
  always @(posedge core_clk) begin
    wear <= wear + $countones({evt_out, ctl_out} & ~last);
    last <= {evt_out, ctl_out};
  end
  // field contact change, launched after an edge
  task set_di(input logic [1:0] v);
    @(posedge core_clk);
    di_pin <= v;
  endtask
endmodule
`default_nettype wire

/* File: verification/time_proportional_output_mux_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module time_proportional_output_mux_tb;
  import tpo_pkg::*;
  localparam int TK = 2; // short tick keeps the run small
  logic        core_clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic        heat_drive, cool_drive, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  ctl_is_pulse, di_pin, ctl_out;
  logic [4:0]  int_event;
  logic [2:0]  evt_out;
  int          fails, checks;
  tpo_top #(.TICK_CYCLES(TK)) u_dut (.*);
  tpo_out_drv u_drv (.*);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // widths in clocks, one tick of slack
  task chk_t(input string nm, input int e, input int g);
    checks++;
    if (g < e - TK || g > e + TK) begin
      fails++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // one apb transfer, released only after pready
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      end_sim;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(a, 1'b0, 32'h0);
    chk(nm, e, rd);
  endtask
  task lvl(input logic v, output int n);
    n = 0;
    while (heat_drive !== v && n < 40000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 40000) begin
      fails++;
      end_sim;
    end
  endtask
  // one clean heat pulse after any reconfiguration
  task pulse(output int hi, output int lo);
    int n;
    lvl(1'b0, n);
    lvl(1'b1, n);
    lvl(1'b0, hi);
    lvl(1'b1, lo);
  endtask
  function automatic logic fexp(input logic [2:0] op, input logic [3:0] v);
    case (op)
      3'h3: return (v[0] & v[1]) | (v[2] & v[3]);
      3'h4: return (v[0] | v[1]) & (v[2] | v[3]);
      3'h5: return |v;
      3'h6: return &v;
      default: return v[0];
    endcase
  endfunction
  task t_reset;
    rdchk(A_CYC0, 32'h2, "cyc heat");
    rdchk(A_CYC0 + 8'h04, 32'ha, "cyc cool");
    rdchk(A_CTRL, 32'h0, "mode");
    rdchk(A_OPTY, 32'h0, "op types");
    rdchk(A_POL, 32'h0, "polarity");
    rdchk(A_ASG0, 32'he, "source a");
    rdchk(A_STAT, 32'h280, "status");
    apb(8'h3c, 1'b0, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    $display("reset test done");
  endtask
  task t_clamp;
    apb(A_CYC0, 1'b1, 32'h0);
    rdchk(A_CYC0, 32'h1, "cyc low");
    apb(A_CYC0 + 8'h04, 1'b1, 32'h79);
    rdchk(A_CYC0 + 8'h04, 32'h78, "cyc high");
    apb(A_MIN0 + 8'h04, 1'b1, 32'hfb);
    rdchk(A_MIN0 + 8'h04, 32'hfa, "min high");
    $display("clamp test done");
  endtask
  task t_mux;
    logic [2:0] ops [5];
    ops = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6};
    apb(A_ASG0 + 8'h08, 1'b1, 32'h1440c2);
    foreach (ops[i]) begin
      apb(A_OPTY, 1'b1, {23'h0, ops[i], 6'h0});
      for (int v = 0; v < 16; v++) begin
        int_event <= 5'(v);
        repeat (3) @(posedge core_clk);
        chk("combined", {31'h0, fexp(ops[i], 4'(v))}, {31'h0, evt_out[0]});
      end
    end
    apb(A_POL, 1'b1, 32'h100);
    apb(A_OPTY, 1'b1, 32'h140);
    int_event <= 5'h0;
    repeat (3) @(posedge core_clk);
    chk("inverted", 32'h1, {31'h0, evt_out[0]});
    apb(A_ASG0 + 8'h04, 1'b1, 32'h12);
    apb(A_OPTY, 1'b1, 32'h28);
    u_drv.set_di(2'h1);
    repeat (8) @(posedge core_clk);
    chk("digital in", 32'h1, {31'h0, ctl_out[1]});
    apb(A_OPTY, 1'b1, 32'h0);
    apb(A_POL, 1'b1, 32'h0);
    int_event <= 5'h04;
    repeat (3) @(posedge core_clk);
    chk("events 2 3", 32'h2, {30'h0, evt_out[2:1]});
    $display("mux test done");
  endtask
  task t_duty;
    int hi, lo;
    apb(A_MV0, 1'b1, 32'h1);
    apb(A_MIN0, 1'b1, 32'h0);
    pulse(hi, lo);
    chk_t("on time", 10 * TK, hi);
    chk_t("off time", 990 * TK, lo);
    apb(A_MV0, 1'b1, 32'ha);
    apb(A_MIN0, 1'b1, 32'hfa);
    pulse(hi, lo);
    chk_t("held on", 250 * TK, hi);
    chk_t("held off", 750 * TK, lo);
    $display("duty test done");
  endtask
  task t_relay;
    int hi, lo;
    apb(A_OPTY, 1'b1, 32'h40);
    apb(A_MIN0, 1'b1, 32'h0);
    apb(A_MV0, 1'b1, 32'h1);
    apb(A_STAT, 1'b0, 32'h0);
    chk("relay flags", 32'h380, rd & 32'h380);
    pulse(hi, lo);
    chk_t("relay on", 250 * TK, hi);
    chk_t("relay off", 4750 * TK, lo);
    apb(A_OPTY, 1'b1, 32'h0);
    $display("relay test done");
  endtask
  // life mode on the cool channel: after one on and one off, a new on waits for the next cycle
  task t_life;
    int n;
    apb(A_OPTY, 1'b1, 32'h2a);
    apb(A_CYC0 + 8'h04, 1'b1, 32'h1);
    apb(A_MIN0 + 8'h04, 1'b1, 32'h1);
    apb(A_CTRL, 1'b1, 32'h1);
    apb(A_MV0 + 8'h04, 1'b1, 32'h32);
    n = 0;
    while (cool_drive !== 1'b1 && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    apb(A_MV0 + 8'h04, 1'b1, 32'h0);
    apb(A_MV0 + 8'h04, 1'b1, 32'h64);
    n = 0;
    while (cool_drive !== 1'b1 && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    chk("life refuse", 32'h1, {31'h0, n > 1900 && n < 2010});
    repeat (2) @(posedge core_clk);
    chk("ctl1 cool", 32'h1, {31'h0, ctl_out[0]});
    $display("life test done");
  endtask
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    int_event = 5'h0;
    fails = 0;
    checks = 0;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    t_reset;
    t_clamp;
    t_mux;
    t_duty;
    t_relay;
    t_life;
    end_sim;
  end
  // hang guard, well past the longest pulse wait
  initial begin
    repeat (90000) @(posedge core_clk);
    fails++;
    end_sim;
  end
endmodule
`default_nettype wire
